/* File: core/assc_pkg.sv */
// Shared constants and helpers for the sample sequence control block
package assc_pkg;
   // Bus geometry
   localparam int ASSC_DATA_W = 32;
   localparam int ASSC_ADDR_W = 8;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL       = 8'h00;
   localparam logic [7:0] OFS_TRIGGER    = 8'h04;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK   = 8'h0C;
   localparam logic [7:0] OFS_SEQ_STATUS = 8'h10;
   localparam logic [7:0] OFS_INPUT_SEL  = 8'h40;
   localparam logic [7:0] OFS_SAMPLE_CTL = 8'h44;
   localparam logic [7:0] OFS_SEQ3_CTL   = 8'hA4;
   // Slot layout: one nibble per slot
   localparam int SLOTS     = 8;
   localparam int SLOT_W    = 3;
   localparam int NIB_W     = 4;
   localparam int MUX_W     = 2;
   localparam int CH_W      = 3;
   localparam int BIT_DIFF  = 0;
   localparam int BIT_LAST  = 1;
   localparam int BIT_IE    = 2;
   localparam int BIT_TS    = 3;
   // Writable bits and the fixed high bit; reserved bits read as zero
   localparam logic [31:0] MUX_MASK  = 32'h33333333;
   localparam logic [31:0] SEQ3_MASK = 32'h0000000F;
   localparam logic [31:0] SEQ3_FIX  = 32'h00000002;
   // Control, trigger and status fields
   localparam int CTRL_EN       = 0;
   localparam int TRIG_GO       = 0;
   localparam int STAT_BUSY     = 0;
   localparam int STAT_SLOT_LSB = 4;
   // Interrupt bits
   localparam int IRQ_W    = 2;
   localparam int IRQ_RAW  = 0;
   localparam int IRQ_DONE = 1;
   // Reset values
   localparam logic [31:0] RST_SAMPLE_CTL = 32'h00000000;
   localparam logic [31:0] RST_INPUT_SEL  = 32'h00000000;
   localparam logic [31:0] RST_SEQ3_CTL   = 32'h00000000;
   localparam logic [31:0] RST_WORD       = 32'h00000000;

   // Nibble of a packed per-slot word
   function automatic logic [NIB_W-1:0] slot_nibble(input logic [31:0] word,
                                                    input logic [SLOT_W-1:0] idx);
      logic [31:0] sh;
      sh = word >> {idx, 2'b00};
      return sh[NIB_W-1:0];
   endfunction

   // Byte-lane merge of a write
   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] wdat,
                                            input logic [3:0]  be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = wdat[i*8 +: 8];
         end
      end
      return res;
   endfunction
endpackage

/* File: core/assc_slot_decode.sv */
// Field decode for the slot the sequencer is working on
`timescale 1ns/10ps
`default_nettype none
module assc_slot_decode
   import assc_pkg::*;
(
   input  wire logic [31:0]       ctl_word,
   input  wire logic [31:0]       mux_word,
   input  wire logic [SLOT_W-1:0] slot,
   output logic                   temp_sel,
   output logic                   irq_en,
   output logic                   last,
   output logic                   diff,
   output logic [CH_W-1:0]        pos_ch,
   output logic [CH_W-1:0]        neg_ch
);
   wire logic [NIB_W-1:0] nib;
   wire logic [NIB_W-1:0] mux_nib;
   wire logic [MUX_W-1:0] sel;

   // Pick this slot's nibbles out of both words
   assign nib      = slot_nibble(ctl_word, slot);
   assign mux_nib  = slot_nibble(mux_word, slot);
   assign sel      = mux_nib[MUX_W-1:0];
   assign temp_sel = nib[BIT_TS];
   assign irq_en   = nib[BIT_IE];
   assign last     = nib[BIT_LAST];
   assign diff     = nib[BIT_DIFF];
   // Differential pair i uses pins 2i and 2i+1 single-ended uses pin i
   assign pos_ch   = diff ? {sel, 1'b0} : {1'b0, sel};
   assign neg_ch   = {sel, 1'b1};
endmodule
`default_nettype wire

/* File: core/assc_irq_unit.sv */
// Sticky interrupt status, mask gating and interrupt output flop
`timescale 1ns/10ps
`default_nettype none
module assc_irq_unit
   import assc_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             ce,
   input  wire logic [IRQ_W-1:0] set_evt,
   input  wire logic [IRQ_W-1:0] clr_bits,
   input  wire logic [IRQ_W-1:0] mask,
   output logic      [IRQ_W-1:0] status,
   output logic                  irq
);
   wire logic [IRQ_W-1:0] next_status;

   // A set in the clearing cycle survives
   assign next_status = (status & ~clr_bits) | set_evt;

   // Status and level interrupt, both registered
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         status <= '0;
         irq    <= 1'b0;
      end else if (ce) begin
         status <= next_status;
         irq    <= |(next_status & mask);
      end
   end
endmodule
`default_nettype wire

/* File: core/adc_sample_sequence_control.sv */
// Sample sequencer 0 control: registers, slot stepping and converter requests
//
// Functional notes
// - The sample control register is 32 bits, one nibble per slot.
// - Slot n uses bits 4n+3..4n: temperature, irq enable, last, differential.
// - Temperature select converts the internal sensor, else the selected pin.
// - A slot with irq enable raises the raw flag when its conversion ends.
// - The raw flag reaches the interrupt output only while masked in.
// - Several slots may raise the raw flag within one sequence.
// - The slot flagged last ends the sequence; later slots are never requested.
// - The sequence may end at any of the eight slot positions.
// - The single-slot sequencer 3 has its slot 0 last flag fixed high.
// - Differential select samples that slot's inputs differentially unless temperature select is also set.
// - Differential pair number i converts inputs 2i and 2i+1.
// - Single-ended slots convert the pin whose index equals the select field.
`timescale 1ns/10ps
`default_nettype none
module adc_sample_sequence_control
   import assc_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   reset,
   input  wire logic                   ce,
   // Avalon-MM slave
   input  wire logic [ASSC_ADDR_W-1:0] avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [31:0]            avs_writedata,
   input  wire logic [3:0]             avs_byteenable,
   output logic      [31:0]            avs_readdata,
   output logic                        avs_waitrequest,
   // Sequence start from the trigger source
   input  wire logic                   trigger_in,
   // Converter request and completion
   input  wire logic                   conv_done,
   output logic                        conv_start,
   output logic                        conv_temp_select,
   output logic                        conv_differential,
   output logic      [CH_W-1:0]        conv_pos_channel,
   output logic      [CH_W-1:0]        conv_neg_channel,
   output logic      [SLOT_W-1:0]      conv_slot,
   output logic                        seq_busy,
   output logic                        irq
);
   typedef enum logic [1:0] {
      ASSC_IDLE,
      ASSC_REQUEST,
      ASSC_WAIT_DONE
   } assc_state_t;

   // Registers
   logic [31:0]       sample_control;
   logic [31:0]       input_select;
   logic [31:0]       seq3_control;
   logic              seq_enable;
   logic [IRQ_W-1:0]  irq_mask;
   logic [IRQ_W-1:0]  irq_status;

   // Sequencer state
   assc_state_t       state;
   assc_state_t       next_state;
   logic [SLOT_W-1:0] slot;
   logic [SLOT_W-1:0] next_slot;

   // Bus handshake
   logic              req;
   logic              accept;
   logic              wr_acc;
   logic              rd_acc;
   logic [31:0]       rd_mux;
   logic              hit_ctrl;
   logic              hit_trig;
   logic              hit_istat;
   logic              hit_imask;
   logic              hit_sstat;
   logic              hit_mux;
   logic              hit_ctl;
   logic              hit_seq3;
   logic [31:0]       wr_merged_ctl;
   logic [31:0]       wr_merged_mux;
   logic [31:0]       wr_merged_seq3;
   logic [31:0]       wr_merged_gen;

   // Slot decode results
   logic              d_temp;
   logic              d_ie;
   logic              d_last;
   logic              d_diff;
   logic [CH_W-1:0]   d_pos;
   logic [CH_W-1:0]   d_neg;

   // Events and controls
   logic              go;
   logic              sw_go;
   logic              can_go;
   logic              loading;
   logic              last_pos;
   logic              rd_capture;
   logic              next_waitrequest;
   logic [31:0]       ctrl_word;
   logic [31:0]       seq3_word;
   logic              slot_end;
   logic              seq_end;
   logic [IRQ_W-1:0]  irq_set;
   logic [IRQ_W-1:0]  irq_clr;
   logic [31:0]       seq_status_word;

   // Request is taken at the edge where waitrequest is already low
   assign req    = avs_read | avs_write;
   assign accept = req & ~avs_waitrequest;
   assign wr_acc = accept & avs_write;
   assign rd_acc = accept & avs_read;

   // Address decode
   // Full byte address compared, so aliases of a register read as unmapped
   assign hit_ctrl  = (avs_address == OFS_CTRL);
   assign hit_trig  = (avs_address == OFS_TRIGGER);
   assign hit_istat = (avs_address == OFS_IRQ_STATUS);
   assign hit_imask = (avs_address == OFS_IRQ_MASK);
   assign hit_sstat = (avs_address == OFS_SEQ_STATUS);
   assign hit_mux   = (avs_address == OFS_INPUT_SEL);
   assign hit_ctl   = (avs_address == OFS_SAMPLE_CTL);
   assign hit_seq3  = (avs_address == OFS_SEQ3_CTL);

   // Byte-lane merges for the writable words
   assign wr_merged_ctl  = be_merge(sample_control, avs_writedata, avs_byteenable);
   assign wr_merged_mux  = be_merge(input_select, avs_writedata, avs_byteenable);
   assign wr_merged_seq3 = be_merge(seq3_control, avs_writedata, avs_byteenable);
   assign wr_merged_gen  = be_merge(RST_WORD, avs_writedata, avs_byteenable);

   // Sequencer status word seen by software
   assign seq_status_word = {{(32-STAT_SLOT_LSB-SLOT_W){1'b0}},
                             slot,
                             {(STAT_SLOT_LSB-1){1'b0}},
                             seq_busy};

   // Narrow registers widened to the bus; sequencer 3's fixed last flag reads one
   assign ctrl_word = {31'h00000000, seq_enable};
   assign seq3_word = seq3_control | SEQ3_FIX;

   // Read multiplexer; unmapped offsets read zero
   always_comb begin
      if (hit_ctrl) begin
         rd_mux = ctrl_word;
      end else if (hit_istat) begin
         rd_mux = {30'h00000000, irq_status};
      end else if (hit_imask) begin
         rd_mux = {30'h00000000, irq_mask};
      end else if (hit_sstat) begin
         rd_mux = seq_status_word;
      end else if (hit_mux) begin
         rd_mux = input_select;
      end else if (hit_ctl) begin
         rd_mux = sample_control;
      end else if (hit_seq3) begin
         rd_mux = seq3_word;
      end else begin
         rd_mux = RST_WORD;
      end
   end

   // First edge of a request opens the answer cycle; read data is caught there
   assign next_waitrequest = ~(req & avs_waitrequest);
   assign rd_capture       = req & avs_waitrequest & avs_read;

   // Waitrequest drops for one cycle per request; read data captured with it
   // A registered answer costs a wait state but keeps the bus free of comb paths
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= RST_WORD;
      end else if (ce) begin
         avs_waitrequest <= next_waitrequest;
         if (rd_capture) begin
            avs_readdata <= rd_mux;
         end
      end
   end

   // Status read clears only the bits that were actually returned
   // Read data is used, not live status, so an event in the read cycle survives
   assign irq_clr = (rd_acc & hit_istat) ? avs_readdata[IRQ_W-1:0] : '0;

   // Sample configuration words, written only on the accepting edge
   // Words are read live, so a write mid-run reaches later slots and the last and irq enable flags of the slot in conversion
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sample_control <= RST_SAMPLE_CTL;
         input_select   <= RST_INPUT_SEL;
         seq3_control   <= RST_SEQ3_CTL;
      end else if (ce & wr_acc) begin
         if (hit_ctl) begin
            sample_control <= wr_merged_ctl;
         end
         if (hit_mux) begin
            input_select <= wr_merged_mux & MUX_MASK;
         end
         if (hit_seq3) begin
            // Last flag of slot 0 is held high, so software cannot clear it
            seq3_control <= (wr_merged_seq3 & SEQ3_MASK) | SEQ3_FIX;
         end
      end
   end

   // Enable and mask registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         seq_enable <= 1'b0;
         irq_mask   <= '0;
      end else if (ce & wr_acc) begin
         if (hit_ctrl) begin
            seq_enable <= wr_merged_gen[CTRL_EN];
         end
         if (hit_imask) begin
            irq_mask <= wr_merged_gen[IRQ_W-1:0];
         end
      end
   end

   // Software start: a one written to the trigger bit on the accepting edge
   assign sw_go  = wr_acc & hit_trig & wr_merged_gen[TRIG_GO];
   // Triggers while busy are dropped rather than queued, so none can pile up
   assign can_go = seq_enable & (state == ASSC_IDLE);
   // A trigger starts a sequence only while enabled and idle
   assign go     = can_go & (trigger_in | sw_go);

   // Live decode of the current slot's configuration
   // Decode stays combinational; outputs are registered only in the request cycle
   assc_slot_decode u_decode (
      .ctl_word (sample_control),
      .mux_word (input_select),
      .slot     (slot),
      .temp_sel (d_temp),
      .irq_en   (d_ie),
      .last     (d_last),
      .diff     (d_diff),
      .pos_ch   (d_pos),
      .neg_ch   (d_neg)
   );

   // Conversion of the current slot has finished; stray done pulses are ignored
   assign slot_end = (state == ASSC_WAIT_DONE) & conv_done;
   // Highest slot position; nothing exists beyond it to step to
   assign last_pos = (slot == SLOT_W'(SLOTS-1));
   // The flagged slot ends the run; slot 7 stops it even if software forgot
   assign seq_end  = slot_end & (d_last | last_pos);

   // Interrupt events: per-slot raw flag and sequence completion
   assign irq_set[IRQ_RAW]  = slot_end & d_ie;
   assign irq_set[IRQ_DONE] = seq_end;

   // Sequencer next state
   always_comb begin
      next_state = state;
      next_slot  = slot;
      case (state)
         ASSC_IDLE: begin
            if (go) begin
               next_slot  = '0;
               next_state = ASSC_REQUEST;
            end
         end
         ASSC_REQUEST: begin
            next_state = ASSC_WAIT_DONE;
         end
         ASSC_WAIT_DONE: begin
            if (seq_end) begin
               next_state = ASSC_IDLE;
            end else if (slot_end) begin
               next_slot  = slot + 1'b1;
               next_state = ASSC_REQUEST;
            end
         end
         default: begin
            next_state = ASSC_IDLE;
         end
      endcase
   end

   // State and slot registers
   // Slot keeps its value while idle, so status shows where the last run stopped
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= ASSC_IDLE;
         slot  <= '0;
      end else if (ce) begin
         state <= next_state;
         slot  <= next_slot;
      end
   end

   // Busy level for software and the outside
   // Taken from the next state so busy rises together with the request cycle
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         seq_busy <= 1'b0;
      end else if (ce) begin
         seq_busy <= (next_state != ASSC_IDLE);
      end
   end

   // Request cycle: fields of the current slot are loaded into the outputs
   assign loading = (state == ASSC_REQUEST);

   // Converter request: one-cycle start pulse with source held until the next request
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         conv_start        <= 1'b0;
         conv_temp_select  <= 1'b0;
         conv_differential <= 1'b0;
         conv_pos_channel  <= '0;
         conv_neg_channel  <= '0;
         conv_slot         <= '0;
      end else if (ce) begin
         conv_start <= loading;
         if (loading) begin
            conv_temp_select  <= d_temp;
            // Sensor has no differential path, so temperature wins
            conv_differential <= d_diff & ~d_temp;
            conv_pos_channel  <= d_pos;
            conv_neg_channel  <= d_neg;
            conv_slot         <= slot;
         end
      end
   end

   // Sticky status, mask and interrupt output
   // Done bit lets software tell a finished run from a per-slot interrupt
   assc_irq_unit u_irq (
      .clk      (clk),
      .reset    (reset),
      .ce       (ce),
      .set_evt  (irq_set),
      .clr_bits (irq_clr),
      .mask     (irq_mask),
      .status   (irq_status),
      .irq      (irq)
   );
endmodule
`default_nettype wire

/* File: bench/assc_properties.sv */
// Port-level checks for the sample sequence control block
`timescale 1ns/10ps
`default_nettype none
module assc_properties
   import assc_pkg::*;
(
   input wire logic                   clk,
   input wire logic                   reset,
   input wire logic                   ce,
   input wire logic [ASSC_ADDR_W-1:0] avs_address,
   input wire logic                   avs_read,
   input wire logic                   avs_write,
   input wire logic [31:0]            avs_writedata,
   input wire logic [3:0]             avs_byteenable,
   input wire logic [31:0]            avs_readdata,
   input wire logic                   avs_waitrequest,
   input wire logic                   trigger_in,
   input wire logic                   conv_done,
   input wire logic                   conv_start,
   input wire logic                   conv_temp_select,
   input wire logic                   conv_differential,
   input wire logic [CH_W-1:0]        conv_pos_channel,
   input wire logic [CH_W-1:0]        conv_neg_channel,
   input wire logic [SLOT_W-1:0]      conv_slot,
   input wire logic                   seq_busy,
   input wire logic                   irq
);
   logic              have_prev;
   logic [SLOT_W-1:0] prev_slot;

   // Last slot requested in this run; forgotten once idle so a new run starts clean
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         have_prev <= 1'b0;
         prev_slot <= 3'h0;
      end else if (!seq_busy) begin
         have_prev <= 1'b0;
      end else if (conv_start) begin
         have_prev <= 1'b1;
         prev_slot <= conv_slot;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest && ce |=> !avs_waitrequest)
      else $error("bus request not answered in one cycle");
   a_bus_single: assert property (!avs_waitrequest && ce |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_start_pulse: assert property (conv_start |=> !conv_start)
      else $error("conversion request longer than one cycle");
   a_first_slot: assert property ($rose(seq_busy) |=> conv_start && conv_slot == 3'h0)
      else $error("sequence did not begin at slot zero");
   a_slot_order: assert property (conv_start && have_prev |-> conv_slot == prev_slot + 3'h1)
      else $error("slots not requested in ascending order");
   a_start_busy: assert property (conv_start |-> seq_busy)
      else $error("conversion requested outside a sequence");
   a_temp_single: assert property (conv_start |-> !(conv_temp_select && conv_differential))
      else $error("temperature request marked differential");
   a_pair_inputs: assert property (conv_start && conv_differential
                                   |-> !conv_pos_channel[0] && conv_neg_channel == conv_pos_channel + 3'h1)
      else $error("differential pair not 2i and 2i+1");
   a_irq_cause: assert property ($rose(irq) |-> $past(conv_done) || $past(avs_write))
      else $error("interrupt rose without a cause");

   // Main scenarios reached
   c_diff: cover property (conv_start && conv_differential);
   c_slot7: cover property (conv_start && conv_slot == 3'h7);
   c_end: cover property ($fell(seq_busy));
   c_irq: cover property ($rose(irq));
endmodule

bind adc_sample_sequence_control assc_properties u_props (
   .clk(clk), .reset(reset), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .trigger_in(trigger_in),
   .conv_done(conv_done), .conv_start(conv_start), .conv_temp_select(conv_temp_select),
   .conv_differential(conv_differential), .conv_pos_channel(conv_pos_channel),
   .conv_neg_channel(conv_neg_channel), .conv_slot(conv_slot), .seq_busy(seq_busy), .irq(irq));
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the sample sequence control block
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import assc_pkg::*;
;
   logic              clk, reset, ce, avs_read, avs_write, avs_waitrequest, trigger_in, conv_done;
   logic              conv_start, conv_temp_select, conv_differential, seq_busy, irq;
   logic [7:0]        avs_address;
   logic [31:0]       avs_writedata, avs_readdata;
   logic [3:0]        avs_byteenable;
   logic [CH_W-1:0]   conv_pos_channel, conv_neg_channel;
   logic [SLOT_W-1:0] conv_slot;
   int                bad_count, checks, cycles;

   adc_sample_sequence_control uut (
      .clk(clk), .reset(reset), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .trigger_in(trigger_in),
      .conv_done(conv_done), .conv_start(conv_start), .conv_temp_select(conv_temp_select),
      .conv_differential(conv_differential), .conv_pos_channel(conv_pos_channel),
      .conv_neg_channel(conv_neg_channel), .conv_slot(conv_slot), .seq_busy(seq_busy), .irq(irq));

   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Hang guard, well above the several hundred cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         bad_count++;
         end_of_test();
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One Avalon access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd, input logic [3:0] be,
                      output logic [31:0] rd);
      @(posedge clk);
      avs_write <= wr;
      avs_read <= !wr;
      avs_address <= adr;
      avs_writedata <= wd;
      avs_byteenable <= be;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   // Expected {temp, diff, pos, neg} for slot n; temperature wins over differential
   function automatic logic [7:0] exp_fields(input logic [31:0] c, input logic [31:0] m, input int n);
      logic [3:0] nb;
      logic [1:0] mx;
      logic       d;
      nb = c[n*4 +: 4];
      mx = m[n*4 +: 2];
      d = nb[0] & ~nb[3];
      return {nb[3], d, d ? {mx, 1'b0} : {1'b0, mx}, {mx, 1'b1}};
   endfunction

   // Random sequence ending at slot k (k = 8: no last flag), converter answering slowly or promptly
   task automatic run_seq(input int k);
      logic [31:0] c, m, q;
      logic [7:0]  e;
      logic [1:0]  msk;
      logic        raw;
      int          starts;
      c = $urandom & 32'hDDDDDDDD;
      c &= ~((c >> 3) & 32'h11111111);
      if (k < 8) c[k*4+1] = 1'b1;
      m = $urandom & MUX_MASK;
      msk = 2'($urandom);
      raw = 1'b0;
      starts = 0;
      for (int n = 0; n <= k && n < 8; n++) raw |= c[n*4+2];
      bus(1'b1, OFS_SAMPLE_CTL, c, 4'hF, q);
      bus(1'b1, OFS_INPUT_SEL, m, 4'hF, q);
      bus(1'b1, OFS_IRQ_MASK, {30'h0, msk}, 4'hF, q);
      bus(1'b0, OFS_IRQ_STATUS, 32'h0, 4'hF, q);
      if (k % 2 == 1) begin
         bus(1'b1, OFS_TRIGGER, 32'h1, 4'hF, q);
      end else begin
         @(posedge clk);
         trigger_in <= 1'b1;
         @(posedge clk);
         trigger_in <= 1'b0;
      end
      for (int cy = 0; cy < 300; cy++) begin
         @(posedge clk);
         if (conv_start === 1'b1) begin
            e = exp_fields(c, m, starts);
            check("conv_slot", {29'h0, conv_slot}, starts);
            check("conv_fields", {conv_temp_select, conv_differential, conv_pos_channel,
                                  e[6] ? conv_neg_channel : e[2:0]}, e);
            starts++;
            // Trigger while busy must be ignored
            trigger_in <= 1'b1;
            repeat ($urandom_range(3)) @(posedge clk);
            conv_done <= 1'b1;
            @(posedge clk);
            conv_done <= 1'b0;
            trigger_in <= 1'b0;
         end else if (cy > 3 && seq_busy !== 1'b1) begin
            break;
         end
      end
      check("slot_count", starts, k < 8 ? k + 1 : 8);
      check("irq_level", {31'h0, irq}, {31'h0, |({1'b1, raw} & msk)});
      bus(1'b0, OFS_IRQ_STATUS, 32'h0, 4'hF, q);
      check("irq_status", q, {30'h0, 1'b1, raw});
      @(posedge clk);
      check("irq_cleared", {31'h0, irq}, 32'h0);
      $display("Sequence ending at slot %0d done", k);
   endtask

   initial begin
      logic [31:0] q, d;
      void'($urandom(80));
      reset = 1'b1;
      ce = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 8'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
      trigger_in = 1'b0;
      conv_done = 1'b0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      // Reset values, byte lanes, reserved and fixed bits, unmapped place
      bus(1'b0, OFS_SAMPLE_CTL, 32'h0, 4'hF, q);
      check("ctl_reset", q, RST_SAMPLE_CTL);
      bus(1'b1, OFS_SEQ3_CTL, 32'h0, 4'hF, q);
      bus(1'b0, OFS_SEQ3_CTL, 32'h0, 4'hF, q);
      check("seq3_fixed", q, SEQ3_FIX);
      d = $urandom;
      bus(1'b1, OFS_SAMPLE_CTL, d, 4'hF, q);
      bus(1'b1, OFS_SAMPLE_CTL, ~d, 4'h2, q);
      bus(1'b0, OFS_SAMPLE_CTL, 32'h0, 4'hF, q);
      check("ctl_lanes", q, {d[31:16], ~d[15:8], d[7:0]});
      bus(1'b1, OFS_INPUT_SEL, 32'hFFFFFFFF, 4'hF, q);
      bus(1'b0, OFS_INPUT_SEL, 32'h0, 4'hF, q);
      check("mux_reserved", q, MUX_MASK);
      bus(1'b1, 8'h80, 32'hFFFFFFFF, 4'hF, q);
      bus(1'b0, 8'h80, 32'h0, 4'hF, q);
      check("unmapped", q, 32'h0);
      // Trigger ignored while disabled
      @(posedge clk);
      trigger_in <= 1'b1;
      @(posedge clk);
      trigger_in <= 1'b0;
      repeat (4) @(posedge clk);
      check("idle_busy", {31'h0, seq_busy}, 32'h0);
      $display("Register test done");
      bus(1'b1, OFS_CTRL, 32'h1, 4'hF, q);
      // Trigger while the clock enable is low must be lost
      @(posedge clk);
      ce <= 1'b0;
      trigger_in <= 1'b1;
      @(posedge clk);
      trigger_in <= 1'b0;
      repeat (2) @(posedge clk);
      ce <= 1'b1;
      repeat (2) @(posedge clk);
      check("frozen_busy", {31'h0, seq_busy}, 32'h0);
      for (int k = 0; k <= 8; k++) run_seq(k);
      end_of_test();
   end
endmodule
`default_nettype wire
